// ---- sim/dc0b_ctrl_tb_top.sv ----
`default_nettype none
module dc0b_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] ev_sel = 3'h0;
  logic ev_go = 1'b0;
  logic [7:0] reg_rdata, xfer_io_addr, v;
  logic [3:0] tmr_match_a, op_mode;
  logic ser_tx_empty, ser_rx_full, req_n, xfer_stb, xfer_word;
  logic block_area_src, xfer_end_irq, irq, last_word, bad;
  logic [31:0] xfer_src_addr, xfer_dst_addr, last_src, last_dst;
  logic [7:0] tv [5] = '{8'h00, 8'h10, 8'h08, 8'h18, 8'h88};
  logic [3:0] om [5] = '{4'h1, 4'h2, 4'h1, 4'h4, 4'h1};
  logic ei [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] fa [5] = '{8'h91, 8'hd1, 8'hb1, 8'hf1, 8'h81};
  logic [7:0] fb [5] = '{8'h86, 8'h96, 8'hb6, 8'hb6, 8'h86};
  logic [7:0] fs [5] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00};
  logic [7:0] fm [5] = '{8'h5d, 8'h5f, 8'h5e, 8'h5c, 8'h5c};
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_stb = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  dc0b_ctrl i_dc0b_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tmr_match_a(tmr_match_a),
    .ser_tx_empty(ser_tx_empty), .ser_rx_full(ser_rx_full),
    .external_transfer_request_pin_n(req_n), .xfer_stb(xfer_stb),
    .xfer_word(xfer_word), .xfer_src_addr(xfer_src_addr),
    .xfer_dst_addr(xfer_dst_addr), .xfer_io_addr(xfer_io_addr),
    .block_area_src(block_area_src), .op_mode(op_mode),
    .xfer_end_irq(xfer_end_irq), .irq(irq));

  dc0b_partner i_dc0b_partner (.clk(clk), .rst(rst), .ev_sel(ev_sel),
    .ev_go(ev_go), .tmr_match_a(tmr_match_a),
    .ser_tx_empty(ser_tx_empty), .ser_rx_full(ser_rx_full),
    .req_n(req_n));

  // Strobe is sampled at every edge, so each cycle it stands high is counted once
  always @(posedge clk) begin
    cycles++;
    if (xfer_stb === 1'b1) begin
      n_stb++;
      last_src = xfer_src_addr;
      last_dst = xfer_dst_addr;
      last_word = xfer_word;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), {24'h0, d}, {24'h0, exp});
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic fire(input logic [2:0] c, input int nexp);
    int n0;
    n0 = n_stb;
    @(posedge clk);
    ev_sel <= c;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    repeat (5) @(posedge clk);
    chk("strobe count", n_stb - n0, nexp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h2f, 8'h00);
    rchk(8'h28, 8'hff);
    wr(8'h28, 8'h00);
    rchk(8'h28, 8'hff);
    rchk(8'h40, 8'h00);
    wr(8'h29, 8'h12);
    wr(8'h2a, 8'h34);
    wr(8'h2b, 8'h56);
    rchk(8'h2a, 8'h34);
    wr(8'h2e, 8'h5a);
    settle();
    chk("io addr", xfer_io_addr, 8'h5a);
    $display("done: registers");
    for (int c = 0; c < 8; c++) begin
      wr(8'h2f, 8'h80 | c[7:0]);
      fire(c[2:0], 1);
    end
    chk("src", last_src, 32'hff12345d);
    chk("dst", last_dst, 32'hff12345d);
    rchk(8'h2b, 8'h5e);
    wr(8'h2f, 8'hc7);
    fire(3'h7, 1);
    chk("word", last_word, 1);
    rchk(8'h2b, 8'h60);
    wr(8'h2f, 8'ha6);
    fire(3'h6, 1);
    rchk(8'h2b, 8'h5f);
    wr(8'h2f, 8'he6);
    fire(3'h6, 1);
    rchk(8'h2b, 8'h5d);
    $display("done: short mode");
    wr(8'h2f, 8'h00);
    wr(8'h32, 8'hff);
    fire(3'h0, 0);
    rchk(8'h31, 8'h02);
    settle();
    chk("irq masked", irq, 0);
    wr(8'h33, 8'h02);
    settle();
    chk("irq", irq, 1);
    wr(8'h32, 8'h02);
    settle();
    chk("irq cleared", irq, 0);
    foreach (tv[i]) begin
      wr(8'h2f, tv[i]);
      settle();
      chk("op mode", op_mode, om[i]);
      chk("end irq", xfer_end_irq, ei[i]);
    end
    $display("done: modes and interrupts");
    wr(8'h2f, 8'h00);
    wr(8'h22, 8'h10);
    wr(8'h23, 8'h00);
    foreach (fa[i]) begin
      wr(8'h30, fa[i]);
      wr(8'h2f, fb[i]);
      fire(3'h6, 1);
      rchk(8'h23, fs[i]);
      rchk(8'h2b, fm[i]);
    end
    chk("full src", last_src, 32'hff001000);
    chk("full dst", last_dst, 32'hff12345c);
    chk("full io", xfer_io_addr, 8'h00);
    chk("full mode", op_mode, 4'h8);
    wr(8'h2f, 8'h06);
    fire(3'h6, 0);
    for (int m = 0; m < 2; m++) begin
      wr(8'h30, m ? 8'h85 : 8'h81);
      for (int c = 0; c < 8; c++) begin
        wr(8'h2f, 8'h80 | c[7:0]);
        wr(8'h32, 8'hff);
        rd(8'h31, v);
        bad = m ? (c == 4 || c == 5 || c == 7) :
          (c == 1 || (c >= 3 && c < 6));
        chk($sformatf("bad code %0d", c), v[2], bad);
      end
    end
    wr(8'h2f, 8'h80);
    fire(3'h0, 1);
    wr(8'h2f, 8'h8e);
    settle();
    chk("block src", block_area_src, 1);
    wr(8'h2f, 8'h86);
    settle();
    chk("block dst", block_area_src, 0);
    $display("done: full mode");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- sim/dc0b_partner.sv ----
`default_nettype none
module dc0b_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] ev_sel,
  input wire logic ev_go,
  output logic [3:0] tmr_match_a,
  output logic ser_tx_empty,
  output logic ser_rx_full,
  output logic req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle events only; the request pin idles high as if pulled up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_match_a <= 4'h0;
      ser_tx_empty <= 1'b0;
      ser_rx_full <= 1'b0;
      req_n <= 1'b1;
    end else begin
      tmr_match_a <= (ev_go && !ev_sel[2]) ? 4'h1 << ev_sel[1:0] : 4'h0;
      ser_tx_empty <= ev_go && ev_sel == 3'h4;
      ser_rx_full <= ev_go && ev_sel == 3'h5;
      // A one-cycle low gives one falling edge and one low sample
      req_n <= !(ev_go && ev_sel[2:1] == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ---- src/dc0b_cfg.svh ----
`ifndef DC0B_CFG_SVH
`define DC0B_CFG_SVH
// Register byte offsets; wide registers are big-endian, top byte first
`define DC0B_OFS_SRC_TOP 8'h20
`define DC0B_OFS_SRC_LOW 8'h23
`define DC0B_OFS_MAR_TOP 8'h28
`define DC0B_OFS_MAR_LOW 8'h2b
`define DC0B_OFS_IOAR 8'h2e
`define DC0B_OFS_TCR 8'h2f
`define DC0B_OFS_ACTL 8'h30
`define DC0B_OFS_IST 8'h31
`define DC0B_OFS_ICLR 8'h32
`define DC0B_OFS_IEN 8'h33
// Fixed top address byte and reset values
`define DC0B_TOP_ONES 8'hff
`define DC0B_RST_BYTE 8'h00
`define DC0B_RST_ADDR 24'h000000
`define DC0B_RST_EV 3'h0
// Transfer control B bits (short / full meaning)
`define DC0B_B_EN 7
`define DC0B_B_SZ 6
`define DC0B_B_DIR 5
`define DC0B_B_STEP 4
`define DC0B_B_IE 3
// A-half control bits
`define DC0B_A_EN 7
`define DC0B_A_SZ 6
`define DC0B_A_SDIR 5
`define DC0B_A_SSTEP 4
`define DC0B_A_IE 3
`define DC0B_A_BLK 2
`define DC0B_A_FULL 0
// Address steps
`define DC0B_STEP_BYTE 24'h000001
`define DC0B_STEP_WORD 24'h000002
// Activation codes
`define DC0B_ACT_BURST 3'h0
`define DC0B_ACT_STEAL 3'h2
`define DC0B_ACT_TX 3'h4
`define DC0B_ACT_RX 3'h5
`define DC0B_ACT_FALL 3'h6
`define DC0B_ACT_LOW 3'h7
// Event status bits
`define DC0B_EV_XFER 0
`define DC0B_EV_REFUSE 1
`define DC0B_EV_BADCODE 2
`define DC0B_EV_W 3
`endif

// ---- src/dc0b_ctrl.sv ----
// Design decision made here: strobed register access.
`include "dc0b_cfg.svh"
`default_nettype none
module dc0b_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] tmr_match_a,
  input wire logic ser_tx_empty,
  input wire logic ser_rx_full,
  input wire logic external_transfer_request_pin_n,
  output logic xfer_stb,
  output logic xfer_word,
  output logic [31:0] xfer_src_addr,
  output logic [31:0] xfer_dst_addr,
  output logic [7:0] xfer_io_addr,
  output logic block_area_src,
  output logic [3:0] op_mode,
  output logic xfer_end_irq,
  output logic irq
);
  logic [23:0] mar_b_r, mar_b_nxt, src_r, src_nxt;
  logic [7:0] ioar_r, tcr_r, actl_r, rdata_r;
  logic [`DC0B_EV_W-1:0] ist_r, ist_nxt, ien_r, ev_c;
  logic req_prev_r, steal_r, stb_r, word_r, blk_src_r, end_irq_r, irq_r;
  logic [31:0] src_out_r, dst_out_r;
  logic [7:0] io_out_r;
  dc0b_pkg::dc0b_op_type op_r, op_c;
  dc0b_pkg::dc0b_mode_type mode_c;
  logic [2:0] wr_mar, wr_src;
  logic [7:0] mar_lane [3];
  logic [7:0] src_lane [3];
  logic [2:0] code;
  logic trig, bad, en_c, size_c, ie_c, go_c, fall_c, low_c;
  logic wr_ioar, wr_tcr, wr_actl, wr_iclr, wr_ien, full_c;
  logic [7:0] rd_mux;

  function automatic logic [23:0] step_addr(input logic [23:0] a,
      input logic on, input logic down, input logic word);
    logic [23:0] d;
    d = word ? `DC0B_STEP_WORD : `DC0B_STEP_BYTE;
    if (!on) begin
      step_addr = a;
    end else if (down) begin
      step_addr = a - d;
    end else begin
      step_addr = a + d;
    end
  endfunction

  genvar i;
  for (i = 0; i < 3; i++) begin : g_lane
    assign wr_mar[i] = reg_wr && (reg_addr == `DC0B_OFS_MAR_LOW - 8'(i));
    assign wr_src[i] = reg_wr && (reg_addr == `DC0B_OFS_SRC_LOW - 8'(i));
    assign mar_lane[i] = mar_b_r[8*i +: 8];
    assign src_lane[i] = src_r[8*i +: 8];
  end

  assign wr_ioar = reg_wr && (reg_addr == `DC0B_OFS_IOAR);
  assign wr_tcr = reg_wr && (reg_addr == `DC0B_OFS_TCR);
  assign wr_actl = reg_wr && (reg_addr == `DC0B_OFS_ACTL);
  assign wr_iclr = reg_wr && (reg_addr == `DC0B_OFS_ICLR);
  assign wr_ien = reg_wr && (reg_addr == `DC0B_OFS_IEN);

  // Top bytes are constant ones; clear register reads as zero
  assign rd_mux =
    (reg_addr == `DC0B_OFS_MAR_TOP) ? `DC0B_TOP_ONES :
    (reg_addr == `DC0B_OFS_SRC_TOP) ? `DC0B_TOP_ONES :
    (reg_addr == `DC0B_OFS_MAR_LOW - 8'h02) ? mar_lane[2] :
    (reg_addr == `DC0B_OFS_MAR_LOW - 8'h01) ? mar_lane[1] :
    (reg_addr == `DC0B_OFS_MAR_LOW) ? mar_lane[0] :
    (reg_addr == `DC0B_OFS_SRC_LOW - 8'h02) ? src_lane[2] :
    (reg_addr == `DC0B_OFS_SRC_LOW - 8'h01) ? src_lane[1] :
    (reg_addr == `DC0B_OFS_SRC_LOW) ? src_lane[0] :
    (reg_addr == `DC0B_OFS_IOAR) ? ioar_r :
    (reg_addr == `DC0B_OFS_TCR) ? tcr_r :
    (reg_addr == `DC0B_OFS_ACTL) ? actl_r :
    (reg_addr == `DC0B_OFS_IST) ? {5'h00, ist_r} :
    (reg_addr == `DC0B_OFS_IEN) ? {5'h00, ien_r} : `DC0B_RST_BYTE;

  assign full_c = actl_r[`DC0B_A_FULL];
  assign mode_c = !full_c ? dc0b_pkg::DC0B_SHORT :
    actl_r[`DC0B_A_BLK] ? dc0b_pkg::DC0B_FULL_BLK :
    dc0b_pkg::DC0B_FULL_NORM;
  // Full mode needs both the A-half enable and the master enable
  assign en_c = full_c ? (tcr_r[`DC0B_B_EN] && actl_r[`DC0B_A_EN]) :
    tcr_r[`DC0B_B_EN];
  assign size_c = full_c ? actl_r[`DC0B_A_SZ] : tcr_r[`DC0B_B_SZ];
  assign ie_c = full_c ? actl_r[`DC0B_A_IE] : tcr_r[`DC0B_B_IE];
  assign code = tcr_r[2:0];
  assign fall_c = req_prev_r && !external_transfer_request_pin_n;
  assign low_c = !external_transfer_request_pin_n;

  always_comb begin
    trig = 1'b0;
    bad = 1'b0;
    case (mode_c)
      dc0b_pkg::DC0B_SHORT: begin
        if (!code[2]) begin
          trig = tmr_match_a[code[1:0]];
        end else if (code == `DC0B_ACT_TX) begin
          trig = ser_tx_empty;
        end else if (code == `DC0B_ACT_RX) begin
          trig = ser_rx_full;
        end else if (code == `DC0B_ACT_FALL) begin
          trig = fall_c;
        end else begin
          trig = low_c;
        end
      end
      dc0b_pkg::DC0B_FULL_NORM: begin
        if (code == `DC0B_ACT_BURST) begin
          trig = 1'b1;
        end else if (code == `DC0B_ACT_STEAL) begin
          trig = steal_r;
        end else if (code == `DC0B_ACT_FALL) begin
          trig = fall_c;
        end else if (code == `DC0B_ACT_LOW) begin
          trig = low_c;
        end else begin
          bad = 1'b1;
        end
      end
      dc0b_pkg::DC0B_FULL_BLK: begin
        if (!code[2]) begin
          trig = tmr_match_a[code[1:0]];
        end else if (code == `DC0B_ACT_FALL) begin
          trig = fall_c;
        end else begin
          bad = 1'b1;
        end
      end
      default: trig = 1'b0;
    endcase
  end

  // Unavailable codes never transfer; flagged for software instead
  assign go_c = en_c && trig && !bad;

  always_comb begin
    mar_b_nxt = mar_b_r;
    src_nxt = src_r;
    if (go_c && !full_c) begin
      mar_b_nxt = step_addr(mar_b_r, 1'b1, tcr_r[`DC0B_B_DIR],
        size_c);
    end else if (go_c) begin
      mar_b_nxt = step_addr(mar_b_r, tcr_r[`DC0B_B_STEP],
        tcr_r[`DC0B_B_DIR], size_c);
      src_nxt = step_addr(src_r, actl_r[`DC0B_A_SSTEP],
        actl_r[`DC0B_A_SDIR], size_c);
    end
    // Software write of a byte wins over the step in that lane
    for (int k = 0; k < 3; k++) begin
      if (wr_mar[k]) begin
        mar_b_nxt[8*k +: 8] = reg_wdata;
      end
      if (wr_src[k]) begin
        src_nxt[8*k +: 8] = reg_wdata;
      end
    end
  end

  always_comb begin
    op_c = dc0b_pkg::DC0B_OP_FULL;
    if (!full_c && !tcr_r[`DC0B_B_STEP]) begin
      op_c = dc0b_pkg::DC0B_OP_IO;
    end else if (!full_c && !tcr_r[`DC0B_B_IE]) begin
      op_c = dc0b_pkg::DC0B_OP_REPEAT;
    end else if (!full_c) begin
      op_c = dc0b_pkg::DC0B_OP_IDLE;
    end
  end

  assign ev_c = {bad, trig && !en_c && !bad, go_c};
  // Set wins over a clear in the same cycle
  assign ist_nxt = (ist_r & ~(wr_iclr ? reg_wdata[`DC0B_EV_W-1:0] :
    `DC0B_RST_EV)) | ev_c;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mar_b_r <= `DC0B_RST_ADDR;
      src_r <= `DC0B_RST_ADDR;
      ioar_r <= `DC0B_RST_BYTE;
      tcr_r <= `DC0B_RST_BYTE;
      actl_r <= `DC0B_RST_BYTE;
      ist_r <= `DC0B_RST_EV;
      ien_r <= `DC0B_RST_EV;
      rdata_r <= `DC0B_RST_BYTE;
    end else begin
      mar_b_r <= mar_b_nxt;
      src_r <= src_nxt;
      ioar_r <= wr_ioar ? reg_wdata : ioar_r;
      tcr_r <= wr_tcr ? reg_wdata : tcr_r;
      actl_r <= wr_actl ? reg_wdata : actl_r;
      ist_r <= ist_nxt;
      ien_r <= wr_ien ? reg_wdata[`DC0B_EV_W-1:0] : ien_r;
      rdata_r <= reg_rd ? rd_mux : `DC0B_RST_BYTE;
    end
  end

  // Pin history starts high, so a pin already low at reset is taken as a falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_prev_r <= 1'b1;
      steal_r <= 1'b0;
      stb_r <= 1'b0;
      word_r <= 1'b0;
      src_out_r <= 32'h00000000;
      dst_out_r <= 32'h00000000;
      io_out_r <= `DC0B_RST_BYTE;
      blk_src_r <= 1'b0;
      op_r <= dc0b_pkg::DC0B_OP_IO;
      end_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      req_prev_r <= external_transfer_request_pin_n;
      steal_r <= !steal_r;
      stb_r <= go_c;
      word_r <= size_c;
      src_out_r <= {`DC0B_TOP_ONES, full_c ? src_r : mar_b_r};
      dst_out_r <= {`DC0B_TOP_ONES, mar_b_r};
      io_out_r <= full_c ? `DC0B_RST_BYTE : ioar_r;
      blk_src_r <= (mode_c == dc0b_pkg::DC0B_FULL_BLK) &&
        tcr_r[`DC0B_B_IE];
      op_r <= op_c;
      end_irq_r <= ie_c && !en_c;
      irq_r <= |(ist_nxt & ien_r);
    end
  end

  assign reg_rdata = rdata_r;
  assign xfer_stb = stb_r;
  assign xfer_word = word_r;
  assign xfer_src_addr = src_out_r;
  assign xfer_dst_addr = dst_out_r;
  assign xfer_io_addr = io_out_r;
  assign block_area_src = blk_src_r;
  assign op_mode = op_r;
  assign xfer_end_irq = end_irq_r;
  assign irq = irq_r;

  property p_src_inc;
    @(posedge clk) disable iff (rst)
    (go_c && full_c && actl_r[4] && !actl_r[5] && !size_c && !(|wr_src))
    |=> (src_r == $past(src_r) + 24'h000001);
  endproperty
  a_src_inc: assert property (p_src_inc)
    else $error("source byte increment wrong");

  property p_src_dec;
    @(posedge clk) disable iff (rst)
    (go_c && full_c && actl_r[4] && actl_r[5] && size_c && !(|wr_src))
    |=> (src_r == $past(src_r) - 24'h000002);
  endproperty
  a_src_dec: assert property (p_src_dec)
    else $error("source word decrement wrong");

  property p_disabled;
    @(posedge clk) disable iff (rst)
    !tcr_r[7] |=> !xfer_stb;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("transfer while disabled");

  property p_top_ones;
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == 8'h28) |=> (reg_rdata == 8'hff);
  endproperty
  a_top_ones: assert property (p_top_ones)
    else $error("address top byte not all ones");

  property p_short_inc;
    @(posedge clk) disable iff (rst)
    (go_c && !full_c && !tcr_r[5] && tcr_r[6] && !(|wr_mar))
    |=> (mar_b_r == $past(mar_b_r) + 24'h000002) && xfer_stb;
  endproperty
  a_short_inc: assert property (p_short_inc)
    else $error("short mode increment wrong");

  property p_short_dec;
    @(posedge clk) disable iff (rst)
    (go_c && !full_c && tcr_r[5] && !tcr_r[6] && !(|wr_mar))
    |=> (mar_b_r == $past(mar_b_r) - 24'h000001);
  endproperty
  a_short_dec: assert property (p_short_dec)
    else $error("short mode decrement wrong");

  property p_bad_code;
    @(posedge clk) disable iff (rst)
    (mode_c == dc0b_pkg::DC0B_FULL_NORM && code == 3'h1)
    |=> !xfer_stb ##0 ist_r[2];
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("unavailable code transferred");

  property p_blk_tmr;
    @(posedge clk) disable iff (rst)
    (mode_c == dc0b_pkg::DC0B_FULL_BLK && en_c && !code[2]
      && tmr_match_a[code[1:0]]) |=> xfer_stb;
  endproperty
  a_blk_tmr: assert property (p_blk_tmr)
    else $error("block timer trigger missed");

  property p_dst_fixed;
    @(posedge clk) disable iff (rst)
    (go_c && full_c && !tcr_r[4] && !(|wr_mar)) |=> $stable(mar_b_r);
  endproperty
  a_dst_fixed: assert property (p_dst_fixed)
    else $error("destination moved while fixed");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
    (!full_c && !tcr_r[3]) |=> !xfer_end_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("transfer interrupt not suppressed");
endmodule
`default_nettype wire

// ---- src/dc0b_ctrl_fix.sv ----
`default_nettype none
`default_nettype wire

// ---- src/dc0b_pkg.sv ----
`default_nettype none
package dc0b_pkg;
  typedef enum logic [2:0] {
    DC0B_SHORT = 3'b001,
    DC0B_FULL_NORM = 3'b010,
    DC0B_FULL_BLK = 3'b100
  } dc0b_mode_type;
  typedef enum logic [3:0] {
    DC0B_OP_IO = 4'b0001,
    DC0B_OP_REPEAT = 4'b0010,
    DC0B_OP_IDLE = 4'b0100,
    DC0B_OP_FULL = 4'b1000
  } dc0b_op_type;
endpackage
`default_nettype wire
